// File: rtl/tic_timer_irq.sv
// What this block does
// R1: each capture event copies the 16-bit counter into the capture register, except while that register is TOP
// R2: capture register may act as counter TOP when the waveform mode says so
// R3: mask bits 5,2,1,0 gate capture, compare B, compare A, overflow with global enable
// R4: flag register holds capture 5, compare B 2, compare A 1, overflow 0, reset zero
// R5: capture flag sets on capture event, or at TOP when capture is TOP
// R6: a flag clears when its vector executes or when software writes one
// R7: compare flag sets in the timer cycle after counter equals compare value
// R8: forced compare strobes never set a compare flag
// R9: overflow flag sets on overflow in normal and clear-on-match modes
// R10: with sync hold set the written prescaler reset is kept, counter halted
// R11: writing sync hold zero clears prescaler reset and timer resumes
// R12: prescaler reset bit resets prescaler, then self clears unless sync hold
// R13: pin alternate select routes clock, compare outputs and capture input
// R14: writing zero leaves a flag alone; hardware set beats a clearing write
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module tic_timer_irq
    import tic_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic [CNT_W-1:0]      counter_value,
    input  wire logic                  timer_tick,
    input  wire logic [CNT_W-1:0]      compare_a_value,
    input  wire logic [CNT_W-1:0]      compare_b_value,
    input  wire logic [3:0]            waveform_mode_select,
    input  wire logic                  other_mode_ovf_event,
    input  wire logic [1:0]            capture_input_pin,
    input  wire logic                  comparator_out,
    input  wire logic                  comparator_capture_sel,
    input  wire logic [1:0]            ext_clk_pin,
    input  wire logic                  compare_a_wave,
    input  wire logic                  compare_b_wave,
    input  wire logic                  global_irq_enable,
    input  wire logic [N_SRC-1:0]      vector_ack,
    output logic [N_SRC-1:0]           irq_req,
    output logic [CNT_W-1:0]           capture_value_reg,
    output logic                       prescaler_reset_bit,
    output logic                       counter_halt,
    output logic                       ext_clk,
    output logic [1:0]                 compare_a_pin,
    output logic [1:0]                 compare_a_pin_oe,
    output logic [1:0]                 compare_b_pin,
    output logic [1:0]                 compare_b_pin_oe
);

    // ========================================================
    // register bus
    tic_wr_s     wr_req;
    logic        wr_fire;
    logic [7:0]  rd_idx;
    logic [31:0] rd_data;

    tic_axil_slave #(.ADDR_W(AXI_ADDR_W)) u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_req  (wr_req),
        .wr_fire (wr_fire),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    logic wr_lo;
    logic wr_flags;
    logic wr_mask;
    logic wr_gen;
    logic wr_cap;
    assign wr_lo    = wr_fire && wr_req.strb[0];
    assign wr_flags = wr_lo && wr_req.idx == IDX_IRQ_FLAGS;
    assign wr_mask  = wr_lo && wr_req.idx == IDX_IRQ_MASK;
    assign wr_gen   = wr_lo && wr_req.idx == IDX_GEN_CTRL;
    assign wr_cap   = wr_fire && wr_req.idx == IDX_CAPTURE;

    // ========================================================
    // state
    logic [N_SRC-1:0] flags;
    logic [N_SRC-1:0] mask;
    logic             sync_hold_mode;
    logic             pin_alternate_select;
    logic             cap_prev;
    logic             pend_a;
    logic             pend_b;

    logic [N_SRC-1:0] next_flags;
    logic [N_SRC-1:0] next_mask;
    logic             next_sync;
    logic             next_alt;
    logic             next_psr;
    logic             next_cap_prev;
    logic             next_pend_a;
    logic             next_pend_b;
    logic [CNT_W-1:0] next_capture;
    logic [N_SRC-1:0] flag_set;
    logic [N_SRC-1:0] flag_clr;
    logic             cap_src;
    logic             cap_event;
    logic             top_mode;

    always_comb begin
        top_mode      = tic_capture_is_top(waveform_mode_select);
        // edge select lives upstream; a rising level is one event
        cap_src       = comparator_capture_sel ? comparator_out : capture_input_pin[pin_alternate_select]; // R13
        cap_event     = cap_src && !cap_prev;
        next_cap_prev = cap_src;

        // compare matches are only ever seen through equality, so a forced strobe cannot reach them
        next_pend_a = timer_tick ? (counter_value == compare_a_value) : pend_a; // R7
        next_pend_b = timer_tick ? (counter_value == compare_b_value) : pend_b; // R7

        flag_set[SRC_CMP_A]    = timer_tick && pend_a; // R7 R8
        flag_set[SRC_CMP_B]    = timer_tick && pend_b; // R7 R8
        flag_set[SRC_CAPTURE]  = top_mode ? (timer_tick && counter_value == capture_value_reg) : cap_event; // R5
        if (waveform_mode_select == WGM_NORMAL || waveform_mode_select == WGM_CTC) begin
            flag_set[SRC_OVERFLOW] = timer_tick && counter_value == COUNT_MAX; // R9
        end else begin
            flag_set[SRC_OVERFLOW] = other_mode_ovf_event; // R9
        end

        flag_clr = vector_ack; // R6
        if (wr_flags) begin
            flag_clr = flag_clr | {wr_req.data[BIT_CAPTURE], wr_req.data[BIT_CMP_B],
                                   wr_req.data[BIT_CMP_A], wr_req.data[BIT_OVERFLOW]}; // R6
        end
        next_flags = (flags & ~flag_clr) | flag_set; // R14

        next_mask = mask;
        if (wr_mask) begin
            next_mask = {wr_req.data[BIT_CAPTURE], wr_req.data[BIT_CMP_B],
                         wr_req.data[BIT_CMP_A], wr_req.data[BIT_OVERFLOW]}; // R3
        end

        // prescaler reset lasts one cycle unless sync hold keeps it
        next_sync = sync_hold_mode;
        next_alt  = pin_alternate_select;
        next_psr  = prescaler_reset_bit && sync_hold_mode; // R12
        if (wr_gen) begin
            next_sync = wr_req.data[BIT_SYNC_HOLD];
            next_alt  = wr_req.data[BIT_PIN_ALT]; // R13
            next_psr  = wr_req.data[BIT_PSC_RESET]; // R10
            if (!wr_req.data[BIT_SYNC_HOLD] && !wr_req.data[BIT_PSC_RESET]) begin
                next_psr = 1'b0; // R11
            end
        end

        next_capture = capture_value_reg;
        if (wr_cap) begin
            if (wr_req.strb[0]) begin
                next_capture[7:0] = wr_req.data[7:0];
            end
            if (wr_req.strb[1]) begin
                next_capture[15:8] = wr_req.data[15:8];
            end
        end
        // while the register is TOP software owns it, so events do not overwrite it
        if (cap_event && !top_mode) begin
            next_capture = counter_value; // R1 R2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags                <= RST_IRQ_FLAGS[N_SRC-1:0];
            mask                 <= RST_IRQ_MASK[N_SRC-1:0];
            sync_hold_mode       <= RST_GEN_CTRL[BIT_SYNC_HOLD];
            pin_alternate_select <= RST_GEN_CTRL[BIT_PIN_ALT];
            prescaler_reset_bit  <= RST_GEN_CTRL[BIT_PSC_RESET];
            capture_value_reg    <= RST_CAPTURE;
            cap_prev             <= 1'b0;
            pend_a               <= 1'b0;
            pend_b               <= 1'b0;
        end else begin
            flags                <= next_flags;
            mask                 <= next_mask;
            sync_hold_mode       <= next_sync;
            pin_alternate_select <= next_alt;
            prescaler_reset_bit  <= next_psr;
            capture_value_reg    <= next_capture;
            cap_prev             <= next_cap_prev;
            pend_a               <= next_pend_a;
            pend_b               <= next_pend_b;
        end
    end

    // ========================================================
    // outputs and pin routing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req          <= '0;
            counter_halt     <= 1'b0;
            ext_clk          <= 1'b0;
            compare_a_pin    <= 2'h0;
            compare_a_pin_oe <= 2'h0;
            compare_b_pin    <= 2'h0;
            compare_b_pin_oe <= 2'h0;
        end else begin
            irq_req          <= flags & mask & {N_SRC{global_irq_enable}}; // R3
            counter_halt     <= next_sync && next_psr; // R10
            ext_clk          <= ext_clk_pin[next_alt]; // R13
            compare_a_pin    <= next_alt ? {compare_a_wave, 1'b0} : {1'b0, compare_a_wave}; // R13
            compare_a_pin_oe <= next_alt ? 2'h2 : 2'h1;
            compare_b_pin    <= next_alt ? {compare_b_wave, 1'b0} : {1'b0, compare_b_wave}; // R13
            compare_b_pin_oe <= next_alt ? 2'h2 : 2'h1;
        end
    end

    // ========================================================
    // read view
    always_comb begin
        rd_data = 32'h00000000;
        case (rd_idx)
            IDX_CAPTURE: begin
                rd_data[15:0] = capture_value_reg;
            end
            IDX_IRQ_FLAGS: begin
                rd_data[BIT_CAPTURE]  = flags[SRC_CAPTURE]; // R4
                rd_data[BIT_CMP_B]    = flags[SRC_CMP_B];
                rd_data[BIT_CMP_A]    = flags[SRC_CMP_A];
                rd_data[BIT_OVERFLOW] = flags[SRC_OVERFLOW];
            end
            IDX_IRQ_MASK: begin
                rd_data[BIT_CAPTURE]  = mask[SRC_CAPTURE];
                rd_data[BIT_CMP_B]    = mask[SRC_CMP_B];
                rd_data[BIT_CMP_A]    = mask[SRC_CMP_A];
                rd_data[BIT_OVERFLOW] = mask[SRC_OVERFLOW];
            end
            IDX_GEN_CTRL: begin
                rd_data[BIT_SYNC_HOLD] = sync_hold_mode;
                rd_data[BIT_PIN_ALT]   = pin_alternate_select;
                rd_data[BIT_PSC_RESET] = prescaler_reset_bit;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    // ========================================================
    // checks
    AST_CAPTURE_LOAD: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        cap_event && !top_mode |=> capture_value_reg == $past(counter_value))
        else $error("capture register missed the counter value");
    AST_TOP_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        cap_event && top_mode && !wr_cap |=> $stable(capture_value_reg))
        else $error("capture register changed while serving as top");
    AST_IRQ_GLOBAL: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !global_irq_enable || mask == '0 |=> irq_req == '0)
        else $error("interrupt raised without enable");
    AST_FLAGS_RESET: assert property (@(posedge aclk) // R4
        !aresetn |=> flags == '0 && mask == '0)
        else $error("flags not zero after reset");
    AST_CAPTURE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        cap_event && !top_mode |=> flags[SRC_CAPTURE])
        else $error("capture flag not set by event");
    AST_VECTOR_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        vector_ack[SRC_OVERFLOW] && !flag_set[SRC_OVERFLOW] |=> !flags[SRC_OVERFLOW])
        else $error("overflow flag survived its vector");
    AST_CMP_A_NEXT: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        timer_tick && counter_value == compare_a_value ##1 timer_tick |=> flags[SRC_CMP_A])
        else $error("compare a flag late or missing");
    AST_OVF_NORMAL: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        waveform_mode_select == WGM_NORMAL && timer_tick && counter_value == COUNT_MAX |=> flags[SRC_OVERFLOW])
        else $error("overflow flag not set");
    AST_SYNC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        sync_hold_mode && prescaler_reset_bit && !wr_gen |=> prescaler_reset_bit && counter_halt)
        else $error("prescaler reset dropped during sync hold");
    AST_PSR_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        prescaler_reset_bit && !sync_hold_mode && !wr_gen |=> !prescaler_reset_bit)
        else $error("prescaler reset did not self clear");
    AST_PIN_ALTERNATE_SELECT_PINS: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        pin_alternate_select |-> compare_a_pin_oe == 2'h2 && compare_b_pin_oe == 2'h2)
        else $error("compare pins not on alternate set");
    AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        flag_set[SRC_CMP_B] || (flags[SRC_CMP_B] && !flag_clr[SRC_CMP_B]) |=> flags[SRC_CMP_B])
        else $error("compare b flag lost");

    COV_CAPTURE: cover property (@(posedge aclk) disable iff (!aresetn) cap_event && !top_mode);
    COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_req[SRC_CMP_A]));
    COV_PSR_PULSE: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(prescaler_reset_bit) ##1 !prescaler_reset_bit);
    COV_CLEAR_RACE: cover property (@(posedge aclk) disable iff (!aresetn)
        flag_set[SRC_OVERFLOW] && flag_clr[SRC_OVERFLOW]);

endmodule

// File: include/tic_pkg.sv
package tic_pkg;

    // ========================================================
    // register map: printed offsets are indices, byte address = 4 * index
    localparam int          AXI_ADDR_W     = 10;
    localparam logic [7:0]  IDX_CAPTURE    = 8'h22;
    localparam logic [7:0]  IDX_IRQ_FLAGS  = 8'h2A;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h2B;
    localparam logic [7:0]  IDX_GEN_CTRL   = 8'h2F;

    // ========================================================
    // field positions and reset values
    localparam int          BIT_CAPTURE    = 5;
    localparam int          BIT_CMP_B      = 2;
    localparam int          BIT_CMP_A      = 1;
    localparam int          BIT_OVERFLOW   = 0;
    localparam int          BIT_SYNC_HOLD  = 7;
    localparam int          BIT_PIN_ALT    = 1;
    localparam int          BIT_PSC_RESET  = 0;
    localparam logic [7:0]  RST_IRQ_FLAGS  = 8'h00;
    localparam logic [7:0]  RST_IRQ_MASK   = 8'h00;
    localparam logic [7:0]  RST_GEN_CTRL   = 8'h00;
    localparam logic [15:0] RST_CAPTURE    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;

    // ========================================================
    // waveform modes and interrupt source indices
    localparam logic [3:0]  WGM_NORMAL     = 4'h0;
    localparam logic [3:0]  WGM_CTC        = 4'h4;
    localparam int          SRC_OVERFLOW   = 0;
    localparam int          SRC_CMP_A      = 1;
    localparam int          SRC_CMP_B      = 2;
    localparam int          SRC_CAPTURE    = 3;
    localparam int          N_SRC          = 4;

    // ========================================================
    // bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic [7:0]  idx;
        logic [31:0] data;
        logic [3:0]  strb;
    } tic_wr_s;

    // even modes from 8 upward take the capture register as TOP
    function automatic logic tic_capture_is_top(input logic [3:0] wgm);
        return wgm[3] && !wgm[0];
    endfunction

    function automatic logic tic_idx_mapped(input logic [7:0] idx);
        return idx == IDX_CAPTURE || idx == IDX_IRQ_FLAGS || idx == IDX_IRQ_MASK || idx == IDX_GEN_CTRL;
    endfunction

endpackage

// File: rtl/tic_axil_slave.sv
`timescale 1ns/1ns
module tic_axil_slave
    import tic_pkg::*;
#(
    parameter int ADDR_W = AXI_ADDR_W
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output tic_wr_s                wr_req,
    output logic                   wr_fire,
    output logic [7:0]             rd_idx,
    input  wire logic [31:0]       rd_data
);

    // ========================================================
    // write channel: address and data held independently
    logic    aw_held;
    logic    w_held;
    tic_wr_s req;
    logic    next_aw_held;
    logic    next_w_held;
    tic_wr_s next_req;
    logic    next_awready;
    logic    next_wready;
    logic    next_bvalid;
    logic [1:0] next_bresp;

    assign wr_req  = req;
    assign wr_fire = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_req     = req;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_req.idx = awaddr[9:2];
        end
        if (wvalid && wready) begin
            next_w_held   = 1'b1;
            next_req.data = wdata;
            next_req.strb = wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = tic_idx_mapped(req.idx) ? RESP_OKAY : RESP_SLVERR;
        end
        next_awready = !next_aw_held;
        next_wready  = !next_w_held;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            req     <= '0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            req     <= next_req;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // ========================================================
    // read channel: data registered one cycle after the address
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    assign rd_idx = araddr[9:2];

    always_comb begin
        next_arready = arready;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (rvalid && rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = tic_idx_mapped(rd_idx) ? rd_data : 32'h00000000;
            next_rresp   = tic_idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= next_arready | (!arready && !rvalid);
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

endmodule

// File: dv/tic_cpu_model.sv
`timescale 1ns/1ns
module tic_cpu_model
    import tic_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             ack_en,
    input  wire logic [N_SRC-1:0] irq_req,
    output logic      [N_SRC-1:0] vector_ack = '0
);
    // ========================================================
    // core side: one vector at a time, lowest pending source first
    always @(posedge aclk) begin
        vector_ack <= (ack_en && vector_ack == '0) ? (irq_req & (~irq_req + 1'b1)) : '0;
    end
endmodule

// File: dv/tic_timer_irq_tb.sv
`timescale 1ns/1ns
module tic_timer_irq_tb
    import tic_pkg::*;
;
    logic                  aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic                  awready, wready, bvalid, arready, rvalid, prescaler_reset_bit, counter_halt, ext_clk;
    logic                  timer_tick = 0, global_irq_enable = 0, ack_en = 0, compare_a_wave = 0, compare_b_wave = 0;
    logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]           wdata = '0, rdata;
    logic [3:0]            wstrb = 4'hF, irq_req, vector_ack, wgm = WGM_NORMAL;
    logic [1:0]            bresp, rresp, capture_input_pin = '0, ext_clk_pin = '0;
    logic [1:0]            compare_a_pin, compare_a_pin_oe, compare_b_pin, compare_b_pin_oe;
    logic [15:0]           counter_value = '0, compare_a_value = '0, compare_b_value = 16'h0001;
    logic [15:0]           capture_value_reg, rnd = 16'h943C, cap_v;
    logic                  comp_sel = 0, comp_out = 0, ovf_ev = 0;
    int                    err_total = 0, checks = 0, psr_hi = 0, p0;

    tic_timer_irq dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .counter_value, .timer_tick, .compare_a_value, .compare_b_value, .waveform_mode_select(wgm),
        .other_mode_ovf_event(ovf_ev), .capture_input_pin, .comparator_out(comp_out), .comparator_capture_sel(comp_sel),
        .ext_clk_pin, .compare_a_wave, .compare_b_wave, .global_irq_enable, .vector_ack, .irq_req,
        .capture_value_reg, .prescaler_reset_bit, .counter_halt, .ext_clk, .compare_a_pin, .compare_a_pin_oe,
        .compare_b_pin, .compare_b_pin_oe);
    tic_cpu_model cpu (.aclk, .ack_en, .irq_req, .vector_ack);

    always #4 aclk = ~aclk;
    always @(posedge aclk) psr_hi <= psr_hi + int'(prescaler_reset_bit === 1'b1);

    // ========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic chk_pins(input logic a);
        chk({ext_clk, compare_a_pin, compare_b_pin, compare_b_pin_oe}, a ?
            {ext_clk_pin[1], compare_a_wave, 1'b0, compare_b_wave, 3'h2} :
            {ext_clk_pin[0], 1'b0, compare_a_wave, 1'b0, compare_b_wave, 2'h1});
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | awready;
            dd = dd | wready;
            awvalid <= !ad;
            wvalid <= !dd;
        end
        do @(posedge aclk); while (!bvalid);
        chk(bresp, er);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, e);
        chk(rresp, er);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // counter and tick change together, as the counter unit would present them
    task automatic tick(input logic [15:0] c);
        counter_value <= c;
        timer_tick <= 1'b1;
        {ext_clk_pin, compare_a_wave, compare_b_wave} <= rnd[3:0];
        @(posedge aclk);
        timer_tick <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ========================================================
    // scenarios
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
        rd(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
        rd(IDX_GEN_CTRL, 32'h0, RESP_OKAY);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'hFF, RESP_SLVERR);
        chk(compare_a_pin_oe, 2'b01);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            cap_v = rnd & 16'h7FFF;
            counter_value <= cap_v;
            {comp_sel, comp_out, capture_input_pin} <= {i == 2, i == 2, 1'b0, i != 2};
            repeat (3) @(posedge aclk);
            chk(capture_value_reg, cap_v);
            {comp_sel, comp_out, capture_input_pin} <= 4'h0;
            @(posedge aclk);
        end
        rd(IDX_IRQ_FLAGS, 32'h20, RESP_OKAY);
        rnd = lfsr(rnd);
        compare_a_value <= rnd & 16'h7FFF;
        @(posedge aclk);
        tick(rnd & 16'h7FFF);
        rd(IDX_IRQ_FLAGS, 32'h20, RESP_OKAY);
        tick(COUNT_MAX);
        rd(IDX_IRQ_FLAGS, 32'h23, RESP_OKAY);
        wr(IDX_IRQ_FLAGS, 32'h02, RESP_OKAY);
        rd(IDX_IRQ_FLAGS, 32'h21, RESP_OKAY);
        wr(IDX_IRQ_MASK, 32'h21, RESP_OKAY);
        rd(IDX_IRQ_MASK, 32'h21, RESP_OKAY);
        chk(irq_req, 4'h0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(irq_req, 4'h9);
        ack_en <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
        p0 = psr_hi;
        wr(IDX_GEN_CTRL, 32'h01, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(psr_hi - p0, 1);
        wr(IDX_GEN_CTRL, 32'h83, RESP_OKAY);
        chk({prescaler_reset_bit, counter_halt, compare_a_pin_oe}, 4'hE);
        chk_pins(1'b1);
        rd(IDX_GEN_CTRL, 32'h83, RESP_OKAY);
        wr(IDX_GEN_CTRL, 32'h00, RESP_OKAY);
        @(posedge aclk);
        chk({prescaler_reset_bit, counter_halt, compare_a_pin_oe}, 4'h1);
        chk_pins(1'b0);
        ack_en <= 1'b0;
        wgm <= 4'hC;
        capture_input_pin <= 2'b01;
        counter_value <= compare_a_value;
        timer_tick <= 1'b1;
        @(posedge aclk);
        counter_value <= compare_b_value;
        @(posedge aclk);
        counter_value <= cap_v;
        ovf_ev <= 1'b1;
        @(posedge aclk);
        {timer_tick, ovf_ev} <= 2'b00;
        rd(IDX_CAPTURE, cap_v, RESP_OKAY);
        rd(IDX_IRQ_FLAGS, 32'h27, RESP_OKAY);
        wr(IDX_IRQ_FLAGS, 32'h05, RESP_OKAY);
        rd(IDX_IRQ_FLAGS, 32'h22, RESP_OKAY);
        complete_run;
    end
endmodule
